// ===== include/bspe_pkg.sv
// Package with constants and carrier types of the banked stack and priority block.
package bspe_pkg;

  // ------------------------------------------------------------
  // Build options
  // ------------------------------------------------------------
  localparam logic HAS_SEC = 1'b1;
  localparam logic HAS_MAIN = 1'b1;
  localparam int MAX_EXT_IRQ = 496;
  localparam int NUM_EXT = 8;
  localparam logic [7:0] EXT_PRESENT = 8'h3f;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] A_SEL = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_ROUTE = 8'h0c;
  localparam logic [7:0] A_HPRIO1 = 8'h10;
  localparam logic [7:0] A_HPRIO2 = 8'h14;
  localparam logic [7:0] A_HPRIO3 = 8'h18;
  localparam logic [7:0] A_ACTSP = 8'h1c;
  localparam logic [7:0] A_EXTPRIO0 = 8'h20;
  localparam logic [7:0] A_EXTPRIO1 = 8'h24;

  // ------------------------------------------------------------
  // Selector codes and fields
  // ------------------------------------------------------------
  localparam int SEL_NS_BIT = 7;
  localparam logic [6:0] SR_MAIN_SP = 7'h00;
  localparam logic [6:0] SR_PROC_SP = 7'h01;
  localparam logic [6:0] SR_MASK = 7'h02;
  localparam logic [6:0] SR_BASE_PRIORITY_MASK = 7'h03;
  localparam logic [6:0] SR_FAULT_MASK_BIT = 7'h04;
  localparam logic [6:0] SR_CONTROL = 7'h05;
  localparam logic [6:0] SR_MAIN_LIM = 7'h06;
  localparam logic [6:0] SR_PROC_LIM = 7'h07;
  localparam int CTRL_STACK_SELECT_BIT_BIT = 1;
  localparam int ST_HANDLER_BIT = 16;
  localparam int ST_SECURE_BIT = 17;

  // ------------------------------------------------------------
  // Exception numbers and fixed priorities
  // ------------------------------------------------------------
  localparam logic [8:0] EXC_RESET = 9'h001;
  localparam logic [8:0] EXC_NMI = 9'h002;
  localparam logic [8:0] EXC_HARD_FAULT_A = 9'h003;
  localparam logic [8:0] EXC_MEMFAULT = 9'h004;
  localparam logic [8:0] EXC_SECFAULT = 9'h007;
  localparam logic [8:0] EXC_SVC = 9'h00b;
  localparam logic [8:0] EXC_DBGMON = 9'h00c;
  localparam logic [8:0] EXC_PENDABLE_SERVICE = 9'h00e;
  localparam logic [8:0] EXC_TICK = 9'h00f;
  localparam logic [8:0] EXC_EXT_BASE = 9'h010;
  localparam logic signed [9:0] PRIO_RESET = -10'sd4;
  localparam logic signed [9:0] PRIO_HF_ROUTED = -10'sd3;
  localparam logic signed [9:0] PRIO_NMI = -10'sd2;
  localparam logic signed [9:0] PRIO_HF = -10'sd1;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic entry;
    logic ret;
    logic ret_to_thread;
    logic [8:0] num;
    logic stack_done;
    logic sp_wr;
    logic [31:0] sp_data;
    logic state_chg;
    logic state_sec;
  } bspe_evt_t;

  typedef struct packed {
    logic ok;
    logic signed [9:0] prio;
  } bspe_prio_t;

endpackage : bspe_pkg

// ===== rtl/bspe_core.sv
// Banked registers, stack pointer selection and exception priority lookup.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Secure and Non-secure copies kept separately
// - Banked: stack pointers, masks, control, limits, control space
// - Selector bit 7 picks Non-secure copy from Secure; from Non-secure reads zero, ignores writes
// - Four stack pointers with security, else two
// - Handler mode always uses main stack
// - Thread mode stack chosen by select bit
// - Reset selects Secure main stack pointer
// - Stack pointer low two bits read zero
// - After entry stacking, stack doubleword aligned
// - Fixed priorities for reset, NMI, hard fault
// - Configurable exception numbers, reserved 8-10, 13
// - Without main extension 4-10, 12-13 reserved
// - Escalated Secure fault stays Secure hard fault
// - Number 7 reserved without security extension
// - At most 496 external interrupts
// - Absent interrupt priority reads zero, ignores writes
// - Three handler priority registers set priorities
// - Configurable priorities start at zero
// - Status register holds handled exception number
// - Reset enters Thread mode, status zero
module bspe_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bspe_pkg::bspe_evt_t evt_i,
  input wire logic [8:0] lookup_num,
  input wire logic lookup_sec,
  output bspe_pkg::bspe_prio_t lookup_o,
  output logic [31:0] active_sp,
  output logic cur_secure,
  output logic handler_mode
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [31:0] word_fix(input logic [31:0] v);
    word_fix = {v[31:2], 2'b00};
  endfunction : word_fix

  function automatic logic [31:0] dword_fix(input logic [31:0] v);
    dword_fix = {v[31:3], 3'b000};
  endfunction : dword_fix

  function automatic logic cfg_num(input logic [8:0] n);
    logic [8:0] e;
    e = n - bspe_pkg::EXC_EXT_BASE;
    if (n >= bspe_pkg::EXC_EXT_BASE)
    begin
      cfg_num = (e < 9'(bspe_pkg::NUM_EXT)) && (e < 9'(bspe_pkg::MAX_EXT_IRQ))
        && bspe_pkg::EXT_PRESENT[e[2:0]];
    end
    else
    begin
      case (n)
        9'h004, 9'h005, 9'h006: cfg_num = bspe_pkg::HAS_MAIN;
        bspe_pkg::EXC_SECFAULT: cfg_num = bspe_pkg::HAS_MAIN & bspe_pkg::HAS_SEC;
        bspe_pkg::EXC_SVC, bspe_pkg::EXC_PENDABLE_SERVICE, bspe_pkg::EXC_TICK: cfg_num = 1'b1;
        bspe_pkg::EXC_DBGMON: cfg_num = bspe_pkg::HAS_MAIN;
        default: cfg_num = 1'b0;
      endcase
    end
  endfunction : cfg_num

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0] sp_main_reg [2];
  logic [31:0] sp_proc_reg [2];
  logic [31:0] lim_main_reg [2];
  logic [31:0] lim_proc_reg [2];
  logic mask_reg [2];
  logic [7:0] base_priority_mask_reg [2];
  logic fmask_reg [2];
  logic [1:0] ctrl_reg [2];
  logic [7:0] hprio_reg [2][12];
  logic [7:0] ext_reg [bspe_pkg::NUM_EXT];
  logic [31:0] sp_main_next [2];
  logic [31:0] sp_proc_next [2];
  logic [31:0] lim_main_next [2];
  logic [31:0] lim_proc_next [2];
  logic mask_next [2];
  logic [7:0] base_priority_mask_next [2];
  logic fmask_next [2];
  logic [1:0] ctrl_next [2];
  logic [7:0] hprio_next [2][12];
  logic [7:0] ext_next [bspe_pkg::NUM_EXT];
  logic [7:0] sel_reg;
  logic route_reg;
  logic cur_sec_reg;
  logic handler_reg;
  logic [8:0] interrupt_status_reg_reg;
  logic [31:0] rd_val;
  logic rd_err;
  bspe_pkg::bspe_prio_t lk_val;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire dat_wr = wr & (paddr == bspe_pkg::A_DATA);
  wire cur = cur_sec_reg;
  wire acc_raz = sel_reg[bspe_pkg::SEL_NS_BIT] & ~cur_sec_reg;
  wire acc_bank = sel_reg[bspe_pkg::SEL_NS_BIT] ? 1'b0 : cur_sec_reg;
  wire use_proc = ~handler_reg & ctrl_reg[cur][bspe_pkg::CTRL_STACK_SELECT_BIT_BIT];
  wire [31:0] sel_sp = use_proc ? sp_proc_reg[cur] : sp_main_reg[cur];
  wire [1:0] hp_word = 2'(paddr[3:2] - bspe_pkg::A_HPRIO1[3:2]);
  wire hp_hit = (paddr == bspe_pkg::A_HPRIO1) | (paddr == bspe_pkg::A_HPRIO2)
    | (paddr == bspe_pkg::A_HPRIO3);
  wire ext_hit = (paddr == bspe_pkg::A_EXTPRIO0) | (paddr == bspe_pkg::A_EXTPRIO1);
  wire ev_known = (evt_i.num == bspe_pkg::EXC_RESET) | (evt_i.num == bspe_pkg::EXC_NMI)
    | (evt_i.num == bspe_pkg::EXC_HARD_FAULT_A) | cfg_num(evt_i.num);
  wire [8:0] lk_idx = lookup_num - bspe_pkg::EXC_MEMFAULT;
  wire [8:0] lk_ext = lookup_num - bspe_pkg::EXC_EXT_BASE;

  // ------------------------------------------------------------
  // Banked next values
  // ------------------------------------------------------------
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      sp_main_next[b] = sp_main_reg[b];
      sp_proc_next[b] = sp_proc_reg[b];
      lim_main_next[b] = lim_main_reg[b];
      lim_proc_next[b] = lim_proc_reg[b];
      mask_next[b] = mask_reg[b];
      base_priority_mask_next[b] = base_priority_mask_reg[b];
      fmask_next[b] = fmask_reg[b];
      ctrl_next[b] = ctrl_reg[b];
      if (evt_i.sp_wr && (b == 32'(cur)))
      begin
        if (use_proc)
          sp_proc_next[b] = word_fix(evt_i.sp_data);
        else
          sp_main_next[b] = word_fix(evt_i.sp_data);
      end
      if (evt_i.stack_done && (b == 32'(cur)))
      begin
        if (use_proc)
          sp_proc_next[b] = dword_fix(sp_proc_next[b]);
        else
          sp_main_next[b] = dword_fix(sp_main_next[b]);
      end
      if (dat_wr && !acc_raz && (b == 32'(acc_bank)))
      begin
        case (sel_reg[6:0])
          bspe_pkg::SR_MAIN_SP: sp_main_next[b] = word_fix(pwdata);
          bspe_pkg::SR_PROC_SP: sp_proc_next[b] = word_fix(pwdata);
          bspe_pkg::SR_MASK: mask_next[b] = pwdata[0];
          bspe_pkg::SR_BASE_PRIORITY_MASK: base_priority_mask_next[b] = pwdata[7:0];
          bspe_pkg::SR_FAULT_MASK_BIT: fmask_next[b] = pwdata[0];
          bspe_pkg::SR_CONTROL: ctrl_next[b] = pwdata[1:0];
          bspe_pkg::SR_MAIN_LIM: lim_main_next[b] = word_fix(pwdata);
          bspe_pkg::SR_PROC_LIM: lim_proc_next[b] = word_fix(pwdata);
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Priority byte next values
  // ------------------------------------------------------------
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      for (int i = 0; i < 12; i++)
      begin
        hprio_next[b][i] = hprio_reg[b][i];
        if (wr && hp_hit && (b == 32'(cur)) && (i / 4 == 32'(hp_word))
            && pstrb[i % 4] && cfg_num(9'(i + 4)))
          hprio_next[b][i] = pwdata[8 * (i % 4) +: 8];
      end
    end
    for (int i = 0; i < bspe_pkg::NUM_EXT; i++)
    begin
      ext_next[i] = ext_reg[i];
      if (wr && ext_hit && (i / 4 == 32'(paddr[2])) && pstrb[i % 4]
          && bspe_pkg::EXT_PRESENT[i])
        ext_next[i] = pwdata[8 * (i % 4) +: 8];
    end
  end

  // ------------------------------------------------------------
  // Register read selection
  // ------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      bspe_pkg::A_SEL: rd_val = {24'h000000, sel_reg};
      bspe_pkg::A_DATA:
      begin
        if (!acc_raz)
        begin
          case (sel_reg[6:0])
            bspe_pkg::SR_MAIN_SP: rd_val = sp_main_reg[acc_bank];
            bspe_pkg::SR_PROC_SP: rd_val = sp_proc_reg[acc_bank];
            bspe_pkg::SR_MASK: rd_val = {31'h0, mask_reg[acc_bank]};
            bspe_pkg::SR_BASE_PRIORITY_MASK: rd_val = {24'h000000, base_priority_mask_reg[acc_bank]};
            bspe_pkg::SR_FAULT_MASK_BIT: rd_val = {31'h0, fmask_reg[acc_bank]};
            bspe_pkg::SR_CONTROL: rd_val = {30'h0, ctrl_reg[acc_bank]};
            bspe_pkg::SR_MAIN_LIM: rd_val = lim_main_reg[acc_bank];
            bspe_pkg::SR_PROC_LIM: rd_val = lim_proc_reg[acc_bank];
            default: rd_val = 32'h0000_0000;
          endcase
        end
      end
      bspe_pkg::A_STATUS:
      begin
        rd_val[8:0] = interrupt_status_reg_reg;
        rd_val[bspe_pkg::ST_HANDLER_BIT] = handler_reg;
        rd_val[bspe_pkg::ST_SECURE_BIT] = cur_sec_reg;
      end
      bspe_pkg::A_ROUTE: rd_val = {31'h0, route_reg};
      bspe_pkg::A_ACTSP: rd_val = sel_sp;
      bspe_pkg::A_HPRIO1, bspe_pkg::A_HPRIO2, bspe_pkg::A_HPRIO3:
      begin
        for (int k = 0; k < 4; k++)
          rd_val[8 * k +: 8] = hprio_reg[cur][4 * hp_word + k];
      end
      bspe_pkg::A_EXTPRIO0, bspe_pkg::A_EXTPRIO1:
      begin
        for (int k = 0; k < 4; k++)
          rd_val[8 * k +: 8] = ext_reg[4 * paddr[2] + k];
      end
      default: rd_err = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // Priority lookup
  // ------------------------------------------------------------
  always_comb
  begin
    lk_val.ok = 1'b1;
    lk_val.prio = '0;
    if (lookup_num == bspe_pkg::EXC_RESET)
      lk_val.prio = bspe_pkg::PRIO_RESET;
    else if (lookup_num == bspe_pkg::EXC_NMI)
      lk_val.prio = bspe_pkg::PRIO_NMI;
    else if (lookup_num == bspe_pkg::EXC_HARD_FAULT_A)
      lk_val.prio = (lookup_sec & route_reg) ? bspe_pkg::PRIO_HF_ROUTED
        : bspe_pkg::PRIO_HF;
    else if (!cfg_num(lookup_num))
      lk_val.ok = 1'b0;
    else if (lookup_num < bspe_pkg::EXC_EXT_BASE)
      lk_val.prio = {2'b00, hprio_reg[lookup_sec][lk_idx[3:0]]};
    else
      lk_val.prio = {2'b00, ext_reg[lk_ext[2:0]]};
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < 2; b++)
      begin
        sp_main_reg[b] <= bspe_pkg::SP_RESET;
        sp_proc_reg[b] <= bspe_pkg::SP_RESET;
        lim_main_reg[b] <= 32'h0000_0000;
        lim_proc_reg[b] <= 32'h0000_0000;
        mask_reg[b] <= 1'b0;
        base_priority_mask_reg[b] <= 8'h00;
        fmask_reg[b] <= 1'b0;
        ctrl_reg[b] <= 2'h0;
        for (int i = 0; i < 12; i++)
          hprio_reg[b][i] <= 8'h00;
      end
      for (int i = 0; i < bspe_pkg::NUM_EXT; i++)
        ext_reg[i] <= 8'h00;
    end
    else
    begin
      sp_main_reg <= sp_main_next;
      sp_proc_reg <= sp_proc_next;
      lim_main_reg <= lim_main_next;
      lim_proc_reg <= lim_proc_next;
      mask_reg <= mask_next;
      base_priority_mask_reg <= base_priority_mask_next;
      fmask_reg <= fmask_next;
      ctrl_reg <= ctrl_next;
      hprio_reg <= hprio_next;
      ext_reg <= ext_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_sec_reg <= bspe_pkg::HAS_SEC;
      handler_reg <= 1'b0;
      interrupt_status_reg_reg <= 9'h000;
      sel_reg <= 8'h00;
      route_reg <= 1'b0;
    end
    else
    begin
      if (evt_i.state_chg)
        cur_sec_reg <= evt_i.state_sec & bspe_pkg::HAS_SEC;
      if (evt_i.entry && ev_known)
      begin
        handler_reg <= 1'b1;
        interrupt_status_reg_reg <= evt_i.num;
      end
      else if (evt_i.ret)
      begin
        handler_reg <= ~evt_i.ret_to_thread;
        interrupt_status_reg_reg <= evt_i.ret_to_thread ? 9'h000 : evt_i.num;
      end
      if (wr && paddr == bspe_pkg::A_SEL)
        sel_reg <= pwdata[7:0];
      if (wr && paddr == bspe_pkg::A_ROUTE && cur_sec_reg)
        route_reg <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      active_sp <= bspe_pkg::SP_RESET;
      lookup_o <= '0;
      cur_secure <= 1'b0;
      handler_mode <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & rd_err;
      prdata <= (setup & ~pwrite & ~rd_err) ? rd_val : 32'h0000_0000;
      active_sp <= sel_sp;
      lookup_o <= lk_val;
      cur_secure <= cur_sec_reg;
      handler_mode <= handler_reg;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_handler_main;
    handler_reg |=> active_sp == $past(sp_main_reg[cur]);
  endproperty
  a_handler_main: assert property (p_handler_main) else $error("handler not on main");

  property p_thread_proc;
    !handler_reg && ctrl_reg[cur][1] |=> active_sp == $past(sp_proc_reg[cur]);
  endproperty
  a_thread_proc: assert property (p_thread_proc) else $error("thread stack wrong");

  property p_word;
    sp_main_reg[0][1:0] == 2'b00 && sp_main_reg[1][1:0] == 2'b00
      && sp_proc_reg[0][1:0] == 2'b00 && sp_proc_reg[1][1:0] == 2'b00;
  endproperty
  a_word: assert property (p_word) else $error("stack pointer not aligned");

  property p_dword;
    evt_i.stack_done && !dat_wr && !evt_i.state_chg |=> sel_sp[2:0] == 3'b000;
  endproperty
  a_dword: assert property (p_dword) else $error("stack not doubleword aligned");

  property p_raz;
    setup && !pwrite && paddr == bspe_pkg::A_DATA && acc_raz |=> prdata == 32'h0;
  endproperty
  a_raz: assert property (p_raz) else $error("non-secure alias not zero");

  property p_nmi;
    lookup_num == bspe_pkg::EXC_NMI |=> lookup_o.ok && lookup_o.prio == -10'sd2;
  endproperty
  a_nmi: assert property (p_nmi) else $error("NMI priority wrong");

  property p_hf_sec;
    lookup_num == bspe_pkg::EXC_HARD_FAULT_A && lookup_sec && route_reg
      |=> lookup_o.prio == -10'sd3;
  endproperty
  a_hf_sec: assert property (p_hf_sec) else $error("secure hard fault wrong");

  property p_resv;
    lookup_num inside {9'h008, 9'h009, 9'h00a, 9'h00d} |=> !lookup_o.ok;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved number accepted");

  property p_absent;
    ext_reg[6] == 8'h00 && ext_reg[7] == 8'h00;
  endproperty
  a_absent: assert property (p_absent) else $error("absent priority not zero");

  property p_entry;
    evt_i.entry && ev_known |=> handler_reg && interrupt_status_reg_reg == $past(evt_i.num);
  endproperty
  a_entry: assert property (p_entry) else $error("status not exception number");

  property p_thread_zero;
    !handler_reg |-> interrupt_status_reg_reg == 9'h000;
  endproperty
  a_thread_zero: assert property (p_thread_zero) else $error("thread status nonzero");

  c_entry: cover property (evt_i.entry && ev_known ##1 handler_reg);
  c_raz: cover property (setup && paddr == bspe_pkg::A_DATA && acc_raz);
  c_stack: cover property (evt_i.stack_done && handler_reg);
  c_hf: cover property (lookup_num == bspe_pkg::EXC_HARD_FAULT_A && route_reg && lookup_sec);

endmodule : bspe_core
`default_nettype wire

// ===== testbench/bspe_pipe_model.sv
// Pipeline partner model that sends exception and stack events into the block.
`timescale 1ns/1ps
`default_nettype none
module bspe_pipe_model (
  input wire logic pclk,
  output bspe_pkg::bspe_evt_t evt
);
  initial evt = '0;

  // Sends one event for a single cycle, then scrambles the data fields.
  task send(input bspe_pkg::bspe_evt_t e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
    evt.num <= ~e.num;
    evt.sp_data <= ~e.sp_data;
  endtask : send
endmodule : bspe_pipe_model
`default_nettype wire

// ===== testbench/bspe_core_tb.sv
// Self-checking testbench of the banked stack and priority block.
`timescale 1ns/1ps
`default_nettype none
module bspe_core_tb;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, cur_secure, handler_mode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, active_sp, rd_v;
  logic [3:0] pstrb;
  logic [8:0] lookup_num;
  logic lookup_sec, rd_e;
  bspe_pkg::bspe_evt_t evt, e;
  bspe_pkg::bspe_prio_t lookup_o;
  int miscompares = 0;
  int tests_run = 0;
  localparam logic [8:0] LN [12] = '{1, 2, 3, 3, 4, 6, 8, 13, 11, 14, 15, 16};
  localparam logic LS [12] = '{1, 1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1};
  localparam logic [10:0] LE [12] = '{11'h7fc, 11'h7fe, 11'h7ff, 11'h7fd, 11'h400, 11'h433,
    11'h000, 11'h000, 11'h4ff, 11'h477, 11'h488, 11'h401};

  bspe_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_i(evt), .lookup_num(lookup_num),
    .lookup_sec(lookup_sec), .lookup_o(lookup_o), .active_sp(active_sp),
    .cur_secure(cur_secure), .handler_mode(handler_mode));
  bspe_pipe_model pipe (.pclk(pclk), .evt(evt));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task wrap_up;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      wrap_up();
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp, "read");
  endtask : rd

  task do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task ev(input int k, input logic [8:0] n, input logic [31:0] d);
    e = '0;
    e.num = n;
    e.sp_data = d;
    e.entry = (k == 0);
    e.ret = (k == 1);
    e.ret_to_thread = (k == 1);
    e.stack_done = (k == 2);
    e.sp_wr = (k == 3);
    e.state_chg = (k == 4);
    pipe.send(e);
  endtask : ev

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    lookup_num = 9'h000;
    lookup_sec = 1'b0;
    do_reset();
    rd(bspe_pkg::A_STATUS, 32'h0002_0000);
    rd(bspe_pkg::A_ACTSP, 32'h0000_0000);
    chk(cur_secure, 1'b1, "secure after reset");
    wr(bspe_pkg::A_SEL, 32'h0000_0000);
    wr(bspe_pkg::A_DATA, 32'h1234_5677);
    rd(bspe_pkg::A_DATA, 32'h1234_5674);
    wr(bspe_pkg::A_SEL, 32'h0000_0080);
    wr(bspe_pkg::A_DATA, 32'h0000_a008);
    wr(bspe_pkg::A_SEL, 32'h0000_0000);
    rd(bspe_pkg::A_DATA, 32'h1234_5674);
    rd(bspe_pkg::A_ACTSP, 32'h1234_5674);
    wr(bspe_pkg::A_SEL, 32'h0000_0001);
    wr(bspe_pkg::A_DATA, 32'h0000_3004);
    wr(bspe_pkg::A_SEL, 32'h0000_0005);
    wr(bspe_pkg::A_DATA, 32'h0000_0002);
    rd(bspe_pkg::A_ACTSP, 32'h0000_3004);
    chk(active_sp, 32'h0000_3004, "active stack output");
    ev(0, bspe_pkg::EXC_SVC, 32'h0000_0000);
    rd(bspe_pkg::A_STATUS, 32'h0003_000b);
    rd(bspe_pkg::A_ACTSP, 32'h1234_5674);
    chk(handler_mode, 1'b1, "handler mode");
    ev(2, 9'h000, 32'h0000_0000);
    rd(bspe_pkg::A_ACTSP, 32'h1234_5670);
    ev(3, 9'h000, 32'h0000_5003);
    rd(bspe_pkg::A_ACTSP, 32'h0000_5000);
    ev(0, 9'h008, 32'h0000_0000);
    rd(bspe_pkg::A_STATUS, 32'h0003_000b);
    ev(1, 9'h000, 32'h0000_0000);
    rd(bspe_pkg::A_STATUS, 32'h0002_0000);
    rd(bspe_pkg::A_ACTSP, 32'h0000_3004);
    wr(bspe_pkg::A_HPRIO1, 32'h4433_2200);
    rd(bspe_pkg::A_HPRIO1, 32'h4433_2200);
    wr(bspe_pkg::A_HPRIO2, 32'hffee_ddcc);
    rd(bspe_pkg::A_HPRIO2, 32'hff00_0000);
    wr(bspe_pkg::A_HPRIO3, 32'h8877_6655);
    rd(bspe_pkg::A_HPRIO3, 32'h8877_0055);
    wr(bspe_pkg::A_EXTPRIO1, 32'hddcc_bbaa);
    rd(bspe_pkg::A_EXTPRIO1, 32'h0000_bbaa);
    wr(bspe_pkg::A_EXTPRIO0, 32'h0403_0201);
    wr(bspe_pkg::A_ROUTE, 32'h0000_0001);
    for (int i = 0; i < 12; i++)
    begin
      lookup_num <= LN[i];
      lookup_sec <= LS[i];
      repeat (2) @(posedge pclk);
      #1;
      if (LE[i][10] === 1'b0)
        chk(lookup_o.ok, 1'b0, "reserved number");
      else
        chk(lookup_o, LE[i], "priority lookup");
    end
    ev(4, 9'h000, 32'h0000_0000);
    rd(bspe_pkg::A_STATUS, 32'h0000_0000);
    rd(bspe_pkg::A_HPRIO1, 32'h0000_0000);
    wr(bspe_pkg::A_SEL, 32'h0000_0080);
    wr(bspe_pkg::A_DATA, 32'h7777_0000);
    rd(bspe_pkg::A_DATA, 32'h0000_0000);
    wr(bspe_pkg::A_SEL, 32'h0000_0000);
    rd(bspe_pkg::A_DATA, 32'h0000_a008);
    wr(bspe_pkg::A_ROUTE, 32'h0000_0000);
    rd(bspe_pkg::A_ROUTE, 32'h0000_0001);
    rd(8'h30, 32'h0000_0000);
    chk(rd_e, 1'b1, "unmapped error");
    do_reset();
    rd(bspe_pkg::A_STATUS, 32'h0002_0000);
    rd(bspe_pkg::A_DATA, 32'h0000_0000);
    wrap_up();
  end
endmodule : bspe_core_tb
`default_nettype wire
